// >>> rtl/ccs_defines.vh
// Register indices, field positions, reset values and strobe modes of the core register bank
`ifndef CCS_DEFINES_VH
`define CCS_DEFINES_VH

// Register indices; the APB byte address is four times the index
`define CCS_IDX_STACK        8'h81
`define CCS_IDX_PTR0_LOW     8'h82
`define CCS_IDX_PTR0_HIGH    8'h83
`define CCS_IDX_PTR1_LOW     8'h84
`define CCS_IDX_PTR1_HIGH    8'h85
`define CCS_IDX_XRAM_PAGE    8'h86
`define CCS_IDX_IFACE_CTRL   8'h8F
`define CCS_IDX_PERIPH_OPT   8'h91
`define CCS_IDX_PROG_STATUS  8'hD0
`define CCS_IDX_MAIN_OPER    8'hE0
`define CCS_IDX_SECOND_OPER  8'hF0

// Reset values
`define CCS_RST_STACK        8'h07
`define CCS_RST_ZERO         8'h00

// Program status fields
`define CCS_PSW_CARRY        7
`define CCS_PSW_AUX          6
`define CCS_PSW_USER0        5
`define CCS_PSW_BANK_HI      4
`define CCS_PSW_BANK_LO      3
`define CCS_PSW_EXCESS       2
`define CCS_PSW_USER1        1
`define CCS_PSW_PARITY       0

// Interface control fields
`define CCS_IFC_TIMING       7
`define CCS_IFC_PROTECT      6
`define CCS_IFC_STROBE_HI    3
`define CCS_IFC_STROBE_LO    2
`define CCS_IFC_XRAM_DIS     1
`define CCS_IFC_SELF_PROG    0
`define CCS_IFC_RW_MASK      8'h8F

// Peripheral option: pointer select in bit 0
`define CCS_AUX_PTR_SEL      0

// Strobe output modes
`define CCS_STROBE_TOGGLE    2'h0
`define CCS_STROBE_OFF       2'h1
`define CCS_STROBE_ACCESS    2'h2

// Highest on-chip expanded RAM address and page
`define CCS_XRAM_TOP         16'h03FF
`define CCS_XRAM_TOP_PAGE    8'h03

`endif

// >>> rtl/ccs_sfr_bank.v
// Core special-function register bank with APB access and core-side update ports
// Operation
// - Stack pointer resets to 07h
// - Push or call pre-increments stack pointer
// - Bank select maps working registers in 8-byte banks
// - Parity flag tracks accumulator for even parity
// - Status word field layout, reset to 00h
// - Pointers are 16 bits, whole or bytewise writes
// - Option bit 0 selects second pointer
// - Pointer users operate on selected pointer
// - Page register gives high byte, resets 00h
// - Pages 0-3 internal, else page or latch
// - Pointer moves above 03FFh go external
// - Timing bit: 0 two-clock, 1 one-clock
// - Code protection bit is read-only
// - Strobe control: toggle, off, access-only
// - RAM disable bit 0 enables internal RAM
// - Self-programming enable bit, reset 0
// - Second operand register for multiply, divide, scratch
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
`include "ccs_defines.vh"

module ccs_sfr_bank
(
  // Clock and reset
  input  wire        i_clk,
  input  wire        i_rst,
  // APB slave
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [11:0] i_paddr,
  input  wire [31:0] i_pwdata,
  input  wire [3:0]  i_pstrb,
  output wire [31:0] o_prdata,
  output wire        o_pready,
  output wire        o_pslverr,
  // Core stack and operand updates
  input  wire        i_push,
  input  wire        i_pop,
  input  wire        i_acc_wr,
  input  wire [7:0]  i_acc_data,
  input  wire        i_b_wr,
  input  wire [7:0]  i_b_data,
  input  wire        i_flag_wr,
  input  wire        i_carry,
  input  wire        i_aux_carry,
  input  wire        i_excess,
  input  wire        i_data_pointer_zero_load,
  input  wire [15:0] i_data_pointer_zero_data,
  // External move request
  input  wire        i_movx_req,
  input  wire        i_movx_wide,
  input  wire [7:0]  i_movx_low,
  input  wire [7:0]  i_port2_latch,
  // Code protection pin
  input  wire        i_code_protect,
  // Status towards the core and pins
  output wire [7:0]  o_stack_addr,
  output wire [7:0]  o_sp,
  output wire [4:0]  o_bank_base,
  output wire [15:0] o_data_pointer_zero,
  output wire [7:0]  o_acc,
  output wire [7:0]  o_b,
  output wire [7:0]  o_psw,
  output wire [15:0] o_xaddr,
  output wire        o_xram_int,
  output wire        o_ext_cycle,
  output wire [7:0]  o_port2,
  output wire        o_ale,
  output wire        o_one_t_mode,
  output wire        o_self_prog_en
);

  reg  [31:0] prdata_ff;
  reg         pready_ff;
  reg         pslverr_ff;
  reg  [7:0]  sp_ff;
  reg  [7:0]  stack_addr_ff;
  reg  [7:0]  acc_ff;
  reg  [7:0]  b_ff;
  reg  [7:0]  psw_ff;
  reg  [7:0]  page_ff;
  reg  [7:0]  ifc_ff;
  reg  [7:0]  aux_ff;
  reg  [15:0] data_pointer_zero_out_ff;
  reg  [15:0] xaddr_ff;
  reg         xram_int_ff;
  reg         ext_cycle_ff;
  reg  [7:0]  port2_ff;
  reg         ale_ff;
  reg         prot_meta_ff;
  reg         prot_sync_ff;
  reg  [7:0]  nxt_acc;
  reg  [7:0]  nxt_sp;
  reg  [7:0]  rd_mux;
  reg         rd_hit;
  wire [31:0] ptr_all;
  wire [7:0]  idx;
  wire        aligned;
  wire        wr_en;
  wire        ptr_sel;
  wire [15:0] ptr_cur;

  // Index lives in bits 9:2; anything above or a misaligned byte address is unmapped
  assign idx     = i_paddr[9:2];
  assign aligned = (i_paddr[1:0] == 2'h0) && (i_paddr[11:10] == 2'h0);
  // Writes land only at the access edge with the low byte lane enabled
  assign wr_en   = i_psel && i_penable && pready_ff && i_pwrite && aligned && rd_hit && i_pstrb[0];
  assign ptr_sel = aux_ff[`CCS_AUX_PTR_SEL];
  assign ptr_cur = ptr_sel ? ptr_all[31:16] : ptr_all[15:0];

  // Both pointers, each writable bytewise or as a 16-bit load
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : gen_ptr
      reg [15:0] ptr_ff;
      always @(posedge i_clk)
      begin
        if (i_rst)
          ptr_ff <= {`CCS_RST_ZERO, `CCS_RST_ZERO};
        else if (i_data_pointer_zero_load && (ptr_sel == (g == 1)))
          ptr_ff <= i_data_pointer_zero_data;
        else if (wr_en && (idx == ((g == 1) ? `CCS_IDX_PTR1_LOW : `CCS_IDX_PTR0_LOW)))
          ptr_ff[7:0] <= i_pwdata[7:0];
        else if (wr_en && (idx == ((g == 1) ? `CCS_IDX_PTR1_HIGH : `CCS_IDX_PTR0_HIGH)))
          ptr_ff[15:8] <= i_pwdata[7:0];
      end
      assign ptr_all[16*g+15:16*g] = ptr_ff;
    end
  endgenerate

  // Read decode; unmapped indices answer with an error
  always @*
  begin
    rd_hit = 1'b1;
    case (idx)
      `CCS_IDX_STACK:       rd_mux = sp_ff;
      `CCS_IDX_PTR0_LOW:    rd_mux = ptr_all[7:0];
      `CCS_IDX_PTR0_HIGH:   rd_mux = ptr_all[15:8];
      `CCS_IDX_PTR1_LOW:    rd_mux = ptr_all[23:16];
      `CCS_IDX_PTR1_HIGH:   rd_mux = ptr_all[31:24];
      `CCS_IDX_XRAM_PAGE:   rd_mux = page_ff;
      `CCS_IDX_IFACE_CTRL:  rd_mux = ifc_ff;
      `CCS_IDX_PERIPH_OPT:  rd_mux = aux_ff;
      `CCS_IDX_PROG_STATUS: rd_mux = psw_ff;
      `CCS_IDX_MAIN_OPER:   rd_mux = acc_ff;
      `CCS_IDX_SECOND_OPER: rd_mux = b_ff;
      default:
      begin
        rd_mux = `CCS_RST_ZERO;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Zero-wait slave: ready rises in the access phase, read data captured at setup
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      prdata_ff  <= 32'h00000000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end
    else if (i_psel && !i_penable)
    begin
      prdata_ff  <= (aligned && rd_hit) ? {24'h000000, rd_mux} : 32'h00000000;
      pready_ff  <= 1'b1;
      pslverr_ff <= !(aligned && rd_hit);
    end
    else
    begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end
  end

  // Core-side accumulator write wins over a software write in the same cycle
  always @*
  begin
    nxt_acc = acc_ff;
    if (i_acc_wr)
      nxt_acc = i_acc_data;
    else if (wr_en && idx == `CCS_IDX_MAIN_OPER)
      nxt_acc = i_pwdata[7:0];
  end

  // Stack moves take priority over software writes
  always @*
  begin
    nxt_sp = sp_ff;
    if (i_push)
      nxt_sp = sp_ff + 8'h01;
    else if (i_pop)
      nxt_sp = sp_ff - 8'h01;
    else if (wr_en && idx == `CCS_IDX_STACK)
      nxt_sp = i_pwdata[7:0];
  end

  // Accumulator, second operand, stack
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      acc_ff        <= `CCS_RST_ZERO;
      b_ff          <= `CCS_RST_ZERO;
      sp_ff         <= `CCS_RST_STACK;
      stack_addr_ff <= `CCS_RST_STACK;
    end
    else
    begin
      acc_ff <= nxt_acc;
      if (i_b_wr)
        b_ff <= i_b_data;
      else if (wr_en && idx == `CCS_IDX_SECOND_OPER)
        b_ff <= i_pwdata[7:0];
      sp_ff <= nxt_sp;
      // Store goes to the incremented slot, a read comes from the current top
      if (i_push)
        stack_addr_ff <= sp_ff + 8'h01;
      else if (i_pop)
        stack_addr_ff <= sp_ff;
    end
  end

  // Status word; parity is never software-writable, it follows the accumulator
  always @(posedge i_clk)
  begin
    if (i_rst)
      psw_ff <= `CCS_RST_ZERO;
    else
    begin
      if (i_flag_wr)
      begin
        psw_ff[`CCS_PSW_CARRY]  <= i_carry;
        psw_ff[`CCS_PSW_AUX]    <= i_aux_carry;
        psw_ff[`CCS_PSW_EXCESS] <= i_excess;
      end
      else if (wr_en && idx == `CCS_IDX_PROG_STATUS)
        psw_ff[7:1] <= i_pwdata[7:1];
      psw_ff[`CCS_PSW_PARITY] <= ^nxt_acc;
    end
  end

  // Page, interface control, peripheral option
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      page_ff <= `CCS_RST_ZERO;
      ifc_ff  <= `CCS_RST_ZERO;
      aux_ff  <= `CCS_RST_ZERO;
    end
    else
    begin
      if (wr_en && idx == `CCS_IDX_XRAM_PAGE)
        page_ff <= i_pwdata[7:0];
      if (wr_en && idx == `CCS_IDX_IFACE_CTRL)
        ifc_ff <= i_pwdata[7:0] & `CCS_IFC_RW_MASK;
      // Protection bit shows the pin and ignores writes
      ifc_ff[`CCS_IFC_PROTECT] <= prot_sync_ff;
      if (wr_en && idx == `CCS_IDX_PERIPH_OPT)
        aux_ff <= i_pwdata[7:0];
    end
  end

  // Protection pin is asynchronous to the core clock
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      prot_meta_ff <= 1'b0;
      prot_sync_ff <= 1'b0;
    end
    else
    begin
      prot_meta_ff <= i_code_protect;
      prot_sync_ff <= prot_meta_ff;
    end
  end

  // External move address and path selection
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      xaddr_ff     <= 16'h0000;
      xram_int_ff  <= 1'b0;
      ext_cycle_ff <= 1'b0;
      port2_ff     <= `CCS_RST_ZERO;
      data_pointer_zero_out_ff  <= 16'h0000;
    end
    else
    begin
      data_pointer_zero_out_ff  <= ptr_cur;
      ext_cycle_ff <= 1'b0;
      xram_int_ff  <= 1'b0;
      if (i_movx_req && i_movx_wide)
      begin
        xaddr_ff <= ptr_cur;
        port2_ff <= ptr_cur[15:8];
        if (!ifc_ff[`CCS_IFC_XRAM_DIS] && ptr_cur <= `CCS_XRAM_TOP)
          xram_int_ff <= 1'b1;
        else
          ext_cycle_ff <= 1'b1;
      end
      else if (i_movx_req)
      begin
        if (ifc_ff[`CCS_IFC_XRAM_DIS])
        begin
          // Page register is ignored when on-chip RAM is off
          xaddr_ff     <= {i_port2_latch, i_movx_low};
          port2_ff     <= i_port2_latch;
          ext_cycle_ff <= 1'b1;
        end
        else
        begin
          xaddr_ff <= {page_ff, i_movx_low};
          port2_ff <= page_ff;
          if (page_ff <= `CCS_XRAM_TOP_PAGE)
            xram_int_ff <= 1'b1;
          else
            ext_cycle_ff <= 1'b1;
        end
      end
    end
  end

  // Address latch strobe; reserved code keeps it quiet
  always @(posedge i_clk)
  begin
    if (i_rst)
      ale_ff <= 1'b0;
    else
    begin
      case (ifc_ff[`CCS_IFC_STROBE_HI:`CCS_IFC_STROBE_LO])
        `CCS_STROBE_TOGGLE: ale_ff <= !ale_ff;
        `CCS_STROBE_OFF:    ale_ff <= 1'b0;
        `CCS_STROBE_ACCESS: ale_ff <= i_movx_req && (i_movx_wide ?
                              (ifc_ff[`CCS_IFC_XRAM_DIS] || ptr_cur > `CCS_XRAM_TOP) :
                              (ifc_ff[`CCS_IFC_XRAM_DIS] || page_ff > `CCS_XRAM_TOP_PAGE));
        default:            ale_ff <= 1'b0;
      endcase
    end
  end

  assign o_prdata       = prdata_ff;
  assign o_pready       = pready_ff;
  assign o_pslverr      = pslverr_ff;
  assign o_stack_addr   = stack_addr_ff;
  assign o_sp           = sp_ff;
  // Bank base address is bank number times eight
  assign o_bank_base    = {psw_ff[`CCS_PSW_BANK_HI:`CCS_PSW_BANK_LO], 3'h0};
  assign o_data_pointer_zero         = data_pointer_zero_out_ff;
  assign o_acc          = acc_ff;
  assign o_b            = b_ff;
  assign o_psw          = psw_ff;
  assign o_xaddr        = xaddr_ff;
  assign o_xram_int     = xram_int_ff;
  assign o_ext_cycle    = ext_cycle_ff;
  assign o_port2        = port2_ff;
  assign o_ale          = ale_ff;
  assign o_one_t_mode   = ifc_ff[`CCS_IFC_TIMING];
  assign o_self_prog_en = ifc_ff[`CCS_IFC_SELF_PROG];

endmodule // ccs_sfr_bank

// >>> tb/ccs_sfr_bank_monitor.sv
// Port-level assertions for the core register bank
`timescale 1ns/1ps
module ccs_sfr_bank_monitor
(
  // Clock and reset
  input wire        i_clk,
  input wire        i_rst,
  // Core strobes
  input wire        i_push,
  input wire        i_pop,
  input wire        i_b_wr,
  input wire [7:0]  i_b_data,
  input wire        i_data_pointer_zero_load,
  input wire [15:0] i_data_pointer_zero_data,
  input wire        i_movx_req,
  input wire        i_movx_wide,
  input wire [7:0]  i_movx_low,
  // Observed state
  input wire [7:0]  o_sp,
  input wire [4:0]  o_bank_base,
  input wire [15:0] o_data_pointer_zero,
  input wire [7:0]  o_acc,
  input wire [7:0]  o_b,
  input wire [7:0]  o_psw,
  input wire [15:0] o_xaddr,
  input wire        o_xram_int,
  input wire        o_ext_cycle
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  AST_SP_RESET: assert property ($fell(i_rst) |-> o_sp == 8'h07)
    else $error("stack pointer wrong after reset");
  AST_SP_PUSH: assert property (i_push |=> o_sp == $past(o_sp) + 8'h01)
    else $error("push did not pre-increment");
  AST_SP_POP: assert property (i_pop && !i_push |=> o_sp == $past(o_sp) - 8'h01)
    else $error("pop did not decrement");
  AST_BANK_BASE: assert property (o_bank_base == {o_psw[4:3], 3'b000})
    else $error("bank base mismatch");
  AST_PARITY: assert property (o_psw[0] == ^o_acc)
    else $error("parity flag not even parity");
  AST_B_LOAD: assert property (i_b_wr |=> o_b == $past(i_b_data))
    else $error("second operand not loaded");
  AST_PTR_LOAD: assert property (i_data_pointer_zero_load |-> ##2 o_data_pointer_zero == $past(i_data_pointer_zero_data, 2))
    else $error("pointer load lost");
  AST_MOVX_ONE: assert property (i_movx_req |=> o_xram_int != o_ext_cycle)
    else $error("move not routed to exactly one target");
  AST_MOVX_IDLE: assert property (!i_movx_req |=> !o_xram_int && !o_ext_cycle)
    else $error("move pulse without request");
  AST_WIDE_HIGH: assert property (i_movx_req && i_movx_wide |=> o_xaddr <= 16'h03FF || o_ext_cycle)
    else $error("high pointer move stayed internal");
  AST_NARROW_LOW: assert property (i_movx_req && !i_movx_wide |=> o_xaddr[7:0] == $past(i_movx_low))
    else $error("narrow move low byte wrong");
  cover property (i_push ##1 i_pop);
  cover property (i_movx_req && i_movx_wide ##1 o_ext_cycle);
  cover property (i_data_pointer_zero_load);
endmodule // ccs_sfr_bank_monitor

bind ccs_sfr_bank ccs_sfr_bank_monitor ccs_sfr_bank_monitor_i (.*);

// >>> tb/test_ccs_sfr_bank.sv
// Self-checking bench for the core register bank
`timescale 1ns/1ps
module test_ccs_sfr_bank;
  logic        i_clk = 0, i_rst = 1, i_psel = 0, i_penable = 0, i_pwrite = 0;
  logic        i_push = 0, i_pop = 0, i_acc_wr = 0, i_b_wr = 0, i_flag_wr = 0;
  logic        i_carry = 0, i_aux_carry = 0, i_excess = 0, i_data_pointer_zero_load = 0;
  logic        i_movx_req = 0, i_movx_wide = 0, i_code_protect = 0, er, a;
  logic [7:0]  i_acc_data = 0, i_b_data = 0, i_movx_low = 0, i_port2_latch = 0;
  logic [11:0] i_paddr = 0;
  logic [3:0]  i_pstrb = 4'hF;
  logic [15:0] i_data_pointer_zero_data = 0;
  logic [31:0] i_pwdata = 0, rd;
  wire  [31:0] o_prdata;
  wire         o_pready, o_pslverr, o_xram_int, o_ext_cycle, o_ale, o_one_t_mode, o_self_prog_en;
  wire  [7:0]  o_stack_addr, o_sp, o_acc, o_b, o_psw, o_port2;
  wire  [4:0]  o_bank_base;
  wire  [15:0] o_data_pointer_zero, o_xaddr;
  int          err_count = 0, total_checks = 0, cycles = 0;

  // Only the low byte lane carries data; one scenario drops its strobe
  ccs_sfr_bank ccs_sfr_bank_i (.*);

  initial
    forever #12.5 i_clk = ~i_clk;

  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_count++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wt(input int k);
    repeat (k) @(negedge i_clk);
  endtask

  // Holds the request until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    i_psel <= 1;
    i_penable <= 0;
    i_pwrite <= w;
    i_paddr <= {2'b00, idx, 2'b00};
    i_pwdata <= {24'h0, d};
    @(posedge i_clk);
    i_penable <= 1;
    do
    begin
      @(posedge i_clk);
      n++;
    end
    while (o_pready !== 1'b1 && n < 50);
    rd = o_prdata;
    er = o_pslverr;
    i_psel <= 0;
    i_penable <= 0;
    if (n == 50)
      chk(1'b0, 1'b1);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rd, {24'h0, exp});
    chk(er, 1'b0);
  endtask

  task automatic mv(input logic w, input logic [7:0] lo, input logic [15:0] xa, input logic in);
    @(posedge i_clk);
    i_movx_req <= 1;
    i_movx_wide <= w;
    i_movx_low <= lo;
    @(posedge i_clk) i_movx_req <= 0;
    wt(1);
    chk(o_xaddr, xa);
    chk(o_xram_int, in);
    chk(o_ext_cycle, !in);
  endtask

  task automatic t_reset();
    logic [7:0] ix [11] = '{8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h8F, 8'h91, 8'hD0, 8'hE0, 8'hF0};
    foreach (ix[i]) rdc(ix[i], (i == 0) ? 8'h07 : 8'h00);
    apb(1'b0, 8'h80, 8'h00);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    i_pstrb <= 4'hE;
    wr(8'hF0, 8'h5A);
    i_pstrb <= 4'hF;
    rdc(8'hF0, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_stack();
    @(posedge i_clk) i_push <= 1;
    @(posedge i_clk) i_push <= 0;
    wt(1);
    chk(o_sp, 8'h08);
    chk(o_stack_addr, 8'h08);
    @(posedge i_clk) i_pop <= 1;
    @(posedge i_clk) i_pop <= 0;
    wt(1);
    chk(o_stack_addr, 8'h08);
    rdc(8'h81, 8'h07);
    @(posedge i_clk) i_b_wr <= 1;
    i_b_data <= 8'hA5;
    @(posedge i_clk) i_b_wr <= 0;
    wt(1);
    chk(o_b, 8'hA5);
    rdc(8'hF0, 8'hA5);
    $display("test stack done");
  endtask

  task automatic t_psw();
    for (int rs = 0; rs < 4; rs++)
    begin
      wr(8'hD0, {3'b000, rs[1:0], 3'b000});
      wt(1);
      chk(o_bank_base, rs * 8);
    end
    wr(8'hD0, 8'hE6);
    rdc(8'hD0, 8'hE6);
    @(posedge i_clk) i_acc_wr <= 1;
    i_acc_data <= 8'h0B;
    @(posedge i_clk) i_acc_wr <= 0;
    wt(1);
    chk(o_psw, 8'hE7);
    chk(o_acc, 8'h0B);
    @(posedge i_clk) i_flag_wr <= 1;
    i_aux_carry <= 1;
    @(posedge i_clk) i_flag_wr <= 0;
    wt(1);
    chk(o_psw, 8'h63);
    wr(8'hE0, 8'h03);
    rdc(8'hD0, 8'h62);
    $display("test status done");
  endtask

  task automatic t_ptr();
    wr(8'h82, 8'h34);
    wr(8'h83, 8'h12);
    wt(2);
    chk(o_data_pointer_zero, 16'h1234);
    wr(8'h91, 8'h01);
    @(posedge i_clk) i_data_pointer_zero_load <= 1;
    i_data_pointer_zero_data <= 16'hABCD;
    @(posedge i_clk) i_data_pointer_zero_load <= 0;
    wt(2);
    chk(o_data_pointer_zero, 16'hABCD);
    rdc(8'h84, 8'hCD);
    rdc(8'h85, 8'hAB);
    rdc(8'h82, 8'h34);
    wr(8'h91, 8'h00);
    wt(2);
    chk(o_data_pointer_zero, 16'h1234);
    $display("test pointers done");
  endtask

  task automatic t_movx();
    mv(1'b1, 8'h00, 16'h1234, 1'b0);
    wr(8'h82, 8'hFF);
    wr(8'h83, 8'h03);
    wt(2);
    mv(1'b1, 8'h00, 16'h03FF, 1'b1);
    wr(8'h86, 8'h03);
    mv(1'b0, 8'h5A, 16'h035A, 1'b1);
    wr(8'h86, 8'h04);
    mv(1'b0, 8'h5A, 16'h045A, 1'b0);
    chk(o_port2, 8'h04);
    @(posedge i_clk) i_port2_latch <= 8'hC3;
    wr(8'h8F, 8'h02);
    mv(1'b0, 8'h5A, 16'hC35A, 1'b0);
    mv(1'b1, 8'h00, 16'h03FF, 1'b0);
    $display("test moves done");
  endtask

  task automatic t_ifc();
    wr(8'h8F, 8'hFF);
    rdc(8'h8F, 8'h8F);
    chk(o_one_t_mode, 1'b1);
    chk(o_self_prog_en, 1'b1);
    @(posedge i_clk) i_code_protect <= 1;
    wt(4);
    wr(8'h8F, 8'h00);
    rdc(8'h8F, 8'h40);
    chk(o_one_t_mode, 1'b0);
    chk(o_self_prog_en, 1'b0);
    wt(1);
    a = o_ale;
    wt(1);
    chk(o_ale ^ a, 1'b1);
    for (int m = 1; m < 4; m += 2)
    begin
      wr(8'h8F, m[7:0] << 2);
      mv(1'b0, 8'h11, 16'h0411, 1'b0);
      chk(o_ale, 1'b0);
    end
    wr(8'h8F, 8'h08);
    wt(2);
    chk(o_ale, 1'b0);
    mv(1'b0, 8'h11, 16'h0411, 1'b0);
    chk(o_ale, 1'b1);
    wt(1);
    chk(o_ale, 1'b0);
    $display("test interface done");
  endtask

  initial
  begin
    repeat (10) @(posedge i_clk);
    i_rst <= 0;
    t_reset();
    t_stack();
    t_psw();
    t_ptr();
    t_movx();
    t_ifc();
    conclude();
  end
endmodule // test_ccs_sfr_bank
